// [design/pbr_map.vh]
`ifndef PBR_MAP_VH
`define PBR_MAP_VH
// Command bytes
`define PBR_CLA          8'h00
`define PBR_INS          8'hB0
`define PBR_APDU_LEN     3'h5
`define PBR_SFI_CUR      5'h00
`define PBR_SFI_RFU      5'h1F
`define PBR_LE_MAX       9'h100
// Status words
`define PBR_SW_OK        16'h9000
`define PBR_SW_BAD_LEN   16'h6700
`define PBR_SW_BAD_CLA   16'h6E00
`define PBR_SW_SECURITY  16'h6982
`define PBR_SW_COND      16'h6985
`define PBR_SW_MISSING   16'h6A82
`define PBR_SW_BAD_PARAM 16'h6A86
// Access right codes
`define PBR_ACC_FREE     4'hE
`define PBR_ACC_NONE     4'hF
// Register byte addresses
`define PBR_CTRL_ADR     8'h00
`define PBR_STAT_ADR     8'h04
`define PBR_MADR_ADR     8'h08
`define PBR_MDAT_ADR     8'h0C
`define PBR_FATTR_HI     2'h1
// Control register bits
`define PBR_CTRL_AES     0
`define PBR_CTRL_LRP     1
`define PBR_CTRL_CHAIN   2
`define PBR_CTRL_TAUTH   3
`define PBR_CTRL_SELOK   4
`define PBR_CTRL_SEL     8
`define PBR_CTRL_RST     16'h0000
// File attribute fields
`define PBR_FA_LEN       0
`define PBR_FA_RD        16
`define PBR_FA_RW        20
`define PBR_FA_FLAT      24
`define PBR_FA_EXIST     25
`define PBR_FA_SFI       26
`define PBR_FA_RST       32'h00000000
`endif

// [design/pbr_mem.v]
`timescale 1ns/10ps
`default_nettype none
module pbr_mem #(
  parameter AW = 17,
  parameter DW = 8
) (
  // Clock
  input  wire          clk,
  input  wire          ce,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] wa,
  input  wire [DW-1:0] wd,
  // Registered read port
  input  wire [AW-1:0] ra,
  output reg  [DW-1:0] q_reg
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // File bytes; read is one cycle late so it maps onto block RAM
  always @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[wa] <= wd;
      end
      q_reg <= mem[ra];
    end
  end
endmodule
`default_nettype wire

// [design/pbr_read_cmd.v]
`include "pbr_map.vh"
`timescale 1ns/10ps
`default_nettype none
module pbr_read_cmd #(
  parameter NFILES = 4,
  parameter FIDX_W = 2,
  parameter OFS_W  = 15
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        resetn,
  input  wire        ce,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Command bytes from transport
  input  wire        apdu_valid,
  input  wire [7:0]  apdu_byte,
  input  wire        apdu_last,
  output reg         apdu_ready,
  // Response bytes to transport
  output reg         rsp_valid,
  output reg  [7:0]  rsp_byte,
  output reg         rsp_last,
  input  wire        rsp_ready
);
  localparam S_RX   = 3'h0;
  localparam S_EVAL = 3'h1;
  localparam S_RD   = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_DATA = 3'h4;
  localparam S_SW1  = 3'h5;
  localparam S_SW2  = 3'h6;
  localparam MAW    = FIDX_W + OFS_W;

  reg              rst_meta_reg;
  reg              rst_sync_reg;
  reg  [2:0]       state_reg;
  reg  [7:0]       cla_reg;
  reg  [7:0]       ins_reg;
  reg  [7:0]       p1_reg;
  reg  [7:0]       p2_reg;
  reg  [7:0]       le_reg;
  reg  [2:0]       nbyte_reg;
  reg  [15:0]      ctrl_reg;
  reg  [15:0]      sw_reg;
  reg  [FIDX_W-1:0] cur_idx_reg;
  reg  [14:0]      addr_reg;
  reg  [8:0]       left_reg;
  reg  [MAW-1:0]   madr_reg;
  reg              mwe_reg;
  reg  [MAW-1:0]   mwa_reg;
  reg  [7:0]       mwd_reg;
  wire [7:0]       mem_q;
  wire [32*NFILES-1:0] fattr_w;
  wire [NFILES-1:0] hit;
  wire             rstn;
  wire             wb_req;
  wire [31:0]      wmask;

  ////////////////////////////////////////////////////////////////////////
  // Reset release through two flops; assertion stays asynchronous
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else if (ce) begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rstn = rst_sync_reg;

  // Bus request seen once; ack drops the cycle after it rises
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  ////////////////////////////////////////////////////////////////////////
  // File attribute table, one register per file
  wire       sfi_mode = p1_reg[7];
  wire [4:0] sfid     = p1_reg[4:0];
  genvar gi;
  generate
    for (gi = 0; gi < NFILES; gi = gi + 1) begin : g_file
      localparam [3:0] IDX = gi;
      reg [31:0] attr_reg;
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          attr_reg <= `PBR_FA_RST;
        end else if (ce && wb_req && wb_we_i &&
                     wb_adr_i[7:6] == `PBR_FATTR_HI &&
                     wb_adr_i[5:2] == IDX) begin
          attr_reg <= (attr_reg & ~wmask) | (wb_dat_i & wmask);
        end
      end
      assign fattr_w[32*gi +: 32] = attr_reg;
      // Short identifier lookup, existing files only
      assign hit[gi] = attr_reg[`PBR_FA_EXIST] &&
                       attr_reg[`PBR_FA_SFI +: 5] == sfid;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Command decode and checks
  reg  [FIDX_W-1:0] hit_idx;
  reg               hit_any;
  integer           k;
  always @* begin
    hit_idx = {FIDX_W{1'b0}};
    hit_any = 1'b0;
    for (k = NFILES - 1; k >= 0; k = k - 1) begin
      if (hit[k]) begin
        hit_any = 1'b1;
        hit_idx = k[FIDX_W-1:0];
      end
    end
  end

  wire              sel_ok  = ctrl_reg[`PBR_CTRL_SELOK];
  wire [FIDX_W-1:0] sel_idx = ctrl_reg[`PBR_CTRL_SEL +: FIDX_W];
  wire              by_sfi  = sfi_mode && sfid != `PBR_SFI_CUR;
  // Identifier 00h keeps the selected file
  wire [FIDX_W-1:0] tgt_idx = by_sfi ? hit_idx : sel_idx;
  wire [31:0]       tgt     = fattr_w[32*tgt_idx +: 32];
  wire [15:0]       f_len   = tgt[`PBR_FA_LEN +: 16];
  wire [3:0]        f_rd    = tgt[`PBR_FA_RD +: 4];
  wire [3:0]        f_rw    = tgt[`PBR_FA_RW +: 4];
  // Offset forms: 8-bit with identifier, else 15-bit
  wire [14:0]       ofs     = sfi_mode ? {7'h00, p2_reg}
                                       : {p1_reg[6:0], p2_reg};
  wire [15:0]       avail   = f_len - {1'b0, ofs};
  wire [8:0]        want    = (le_reg == 8'h00) ? `PBR_LE_MAX
                                                : {1'b0, le_reg};
  // Clip to the bytes left in the file
  wire [8:0]        cnt     = (avail < {7'h00, want}) ? avail[8:0]
                                                      : want;

  // Priority chain: length, class, chaining, params, file, rights, offset
  reg [15:0] ev_sw;
  always @* begin
    if (nbyte_reg != `PBR_APDU_LEN) begin
      ev_sw = `PBR_SW_BAD_LEN;
    end else if (cla_reg != `PBR_CLA || ins_reg != `PBR_INS) begin
      ev_sw = `PBR_SW_BAD_CLA;
    end else if (ctrl_reg[`PBR_CTRL_CHAIN]) begin
      ev_sw = `PBR_SW_COND;
    end else if (sfi_mode && (p1_reg[6:5] != 2'h0 ||
                              sfid == `PBR_SFI_RFU)) begin
      ev_sw = `PBR_SW_BAD_PARAM;
    end else if (by_sfi && !hit_any) begin
      ev_sw = `PBR_SW_MISSING;
    end else if (!by_sfi && !sel_ok) begin
      ev_sw = `PBR_SW_COND;
    end else if (!tgt[`PBR_FA_EXIST] || !tgt[`PBR_FA_FLAT]) begin
      ev_sw = `PBR_SW_COND;
    end else if (ctrl_reg[`PBR_CTRL_TAUTH]) begin
      ev_sw = `PBR_SW_COND;
    end else if (f_rd == `PBR_ACC_NONE && f_rw == `PBR_ACC_NONE) begin
      ev_sw = `PBR_SW_SECURITY;
    end else if (f_rd != `PBR_ACC_FREE && f_rw != `PBR_ACC_FREE) begin
      ev_sw = `PBR_SW_SECURITY;
    end else if (ctrl_reg[`PBR_CTRL_AES] || ctrl_reg[`PBR_CTRL_LRP]) begin
      ev_sw = `PBR_SW_SECURITY;
    end else if ({1'b0, ofs} >= f_len) begin
      ev_sw = `PBR_SW_BAD_PARAM;
    end else begin
      ev_sw = `PBR_SW_OK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command engine; software control writes and selection share one
  // process so a hardware selection in the same cycle wins
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= S_RX;
      cla_reg     <= 8'h00;
      ins_reg     <= 8'h00;
      p1_reg      <= 8'h00;
      p2_reg      <= 8'h00;
      le_reg      <= 8'h00;
      nbyte_reg   <= 3'h0;
      ctrl_reg    <= `PBR_CTRL_RST;
      sw_reg      <= `PBR_SW_OK;
      cur_idx_reg <= {FIDX_W{1'b0}};
      addr_reg    <= 15'h0000;
      left_reg    <= 9'h000;
      apdu_ready  <= 1'b0;
      rsp_valid   <= 1'b0;
      rsp_byte    <= 8'h00;
      rsp_last    <= 1'b0;
    end else if (ce) begin
      if (wb_req && wb_we_i && wb_adr_i == `PBR_CTRL_ADR) begin
        ctrl_reg <= (ctrl_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
      end
      case (state_reg)
        S_RX: begin
          apdu_ready <= 1'b1;
          if (apdu_valid && apdu_ready) begin
            // Byte slots; extra bytes only count toward the length
            if (nbyte_reg == 3'h0) begin
              cla_reg <= apdu_byte;
            end else if (nbyte_reg == 3'h1) begin
              ins_reg <= apdu_byte;
            end else if (nbyte_reg == 3'h2) begin
              p1_reg <= apdu_byte;
            end else if (nbyte_reg == 3'h3) begin
              p2_reg <= apdu_byte;
            end else if (nbyte_reg == 3'h4) begin
              le_reg <= apdu_byte;
            end
            if (nbyte_reg != 3'h7) begin
              nbyte_reg <= nbyte_reg + 3'h1;
            end
            if (apdu_last) begin
              apdu_ready <= 1'b0;
              state_reg  <= S_EVAL;
            end
          end
        end
        S_EVAL: begin
          sw_reg <= ev_sw;
          // Referenced file becomes selected once found
          if (nbyte_reg == `PBR_APDU_LEN && cla_reg == `PBR_CLA &&
              ins_reg == `PBR_INS && !ctrl_reg[`PBR_CTRL_CHAIN] &&
              by_sfi && p1_reg[6:5] == 2'h0 && sfid != `PBR_SFI_RFU &&
              hit_any) begin
            ctrl_reg[`PBR_CTRL_SELOK]         <= 1'b1;
            ctrl_reg[`PBR_CTRL_SEL +: FIDX_W] <= hit_idx;
          end
          if (ev_sw == `PBR_SW_OK) begin
            cur_idx_reg <= tgt_idx;
            addr_reg    <= ofs;
            left_reg    <= cnt;
            state_reg   <= S_RD;
          end else begin
            rsp_byte  <= ev_sw[15:8];
            rsp_valid <= 1'b1;
            state_reg <= S_SW1;
          end
        end
        S_RD: begin
          state_reg <= S_WAIT;
        end
        S_WAIT: begin
          // Plain byte straight from storage, no MAC or cipher
          rsp_byte  <= mem_q;
          rsp_valid <= 1'b1;
          state_reg <= S_DATA;
        end
        S_DATA: begin
          if (rsp_ready) begin
            addr_reg <= addr_reg + 15'h0001;
            left_reg <= left_reg - 9'h001;
            if (left_reg == 9'h001) begin
              rsp_byte  <= sw_reg[15:8];
              state_reg <= S_SW1;
            end else begin
              rsp_valid <= 1'b0;
              state_reg <= S_RD;
            end
          end
        end
        S_SW1: begin
          if (rsp_ready) begin
            rsp_byte  <= sw_reg[7:0];
            rsp_last  <= 1'b1;
            state_reg <= S_SW2;
          end
        end
        S_SW2: begin
          if (rsp_ready) begin
            rsp_valid  <= 1'b0;
            rsp_last   <= 1'b0;
            nbyte_reg  <= 3'h0;
            apdu_ready <= 1'b1;
            state_reg  <= S_RX;
          end
        end
        default: begin
          state_reg <= S_RX;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: one-cycle ack, registered read data, memory loading
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      madr_reg <= {MAW{1'b0}};
      mwe_reg  <= 1'b0;
      mwa_reg  <= {MAW{1'b0}};
      mwd_reg  <= 8'h00;
    end else if (ce) begin
      wb_ack_o <= wb_req;
      mwe_reg  <= 1'b0;
      if (wb_req) begin
        if (wb_adr_i == `PBR_CTRL_ADR) begin
          wb_dat_o <= {16'h0000, ctrl_reg};
        end else if (wb_adr_i == `PBR_STAT_ADR) begin
          wb_dat_o <= {15'h0000, state_reg != S_RX, sw_reg};
        end else if (wb_adr_i == `PBR_MADR_ADR) begin
          wb_dat_o <= {{(32-MAW){1'b0}}, madr_reg};
        end else if (wb_adr_i[7:6] == `PBR_FATTR_HI &&
                     wb_adr_i[5:2] < NFILES) begin
          wb_dat_o <= fattr_w[32*wb_adr_i[5:2] +: 32];
        end else begin
          wb_dat_o <= 32'h00000000; // Unmapped reads as zero
        end
        if (wb_we_i && wb_adr_i == `PBR_MADR_ADR) begin
          madr_reg <= wb_dat_i[MAW-1:0];
        end else if (wb_we_i && wb_adr_i == `PBR_MDAT_ADR && wb_sel_i[0]) begin
          // Auto-increment so a file loads as a byte stream
          mwe_reg  <= 1'b1;
          mwa_reg  <= madr_reg;
          mwd_reg  <= wb_dat_i[7:0];
          madr_reg <= madr_reg + {{(MAW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // File storage, one window of 2**OFS_W bytes per file
  pbr_mem #(
    .AW (MAW),
    .DW (8)
  ) u_mem (
    .clk   (mclk),
    .ce    (ce),
    .we    (mwe_reg),
    .wa    (mwa_reg),
    .wd    (mwd_reg),
    .ra    ({cur_idx_reg, addr_reg[OFS_W-1:0]}),
    .q_reg (mem_q)
  );
endmodule
`default_nettype wire

// [bench/pbr_read_cmd_sva.sv]
`timescale 1ns/10ps
`default_nettype none
module pbr_chk (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       ce,
  // Bus handshake
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Command and response streams
  input wire logic       apdu_valid,
  input wire logic       apdu_last,
  input wire logic       apdu_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_last,
  input wire logic       rsp_ready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // Bus answers one cycle after the request, for one cycle only
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  // A request seen with the clock enable high is answered the next cycle
  ack_latency_a: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  ////////////////////////////////////////////////////////////////
  // Response bytes wait for the reader and keep their order
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_byte) && $stable(rsp_last)) else $error("response byte changed while stalled");
  last_valid_a: assert property (rsp_last |-> rsp_valid) else $error("last flag without byte");
  end_frame_a: assert property (rsp_valid && rsp_ready && rsp_last |=> !rsp_valid ##[0:2] apdu_ready)
    else $error("frame did not close");
  // Evaluation before any answer byte, no new command meanwhile
  answer_time_a: assert property (apdu_valid && apdu_ready && apdu_last |-> ##[2:4] rsp_valid)
    else $error("answer not in time");
  apdu_wait_a: assert property (apdu_valid && apdu_ready && apdu_last |=> !apdu_ready)
    else $error("command taken during evaluation");
  // Enable low must hold every handshake output where it is
  clock_freeze_a: assert property (!ce |=> $stable(wb_ack_o) && $stable(apdu_ready) && $stable(rsp_valid))
    else $error("state moved while clock enable low");
  cmd_block_a: assert property (rsp_valid |-> !apdu_ready) else $error("command open while answering");
  // Main scenarios
  frame_c: cover property (rsp_valid && rsp_ready && rsp_last);
  stall_c: cover property (rsp_valid && !rsp_ready);
  bus_c: cover property (wb_ack_o);
  freeze_c: cover property (!ce && wb_cyc_i && wb_stb_i);
endmodule
bind pbr_read_cmd pbr_chk pbr_chk_i (.mclk, .resetn, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .apdu_valid,
  .apdu_last, .apdu_ready, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready);
`default_nettype wire

// [bench/pbr_rdr.sv]
`timescale 1ns/10ps
`default_nettype none
module pbr_rdr (
  // Clock
  input  wire logic       mclk,
  // Command bytes
  output var  logic       apdu_valid,
  output var  logic [7:0] apdu_byte,
  output var  logic       apdu_last,
  input  wire logic       apdu_ready,
  // Response bytes
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  input  wire logic       rsp_last,
  output var  logic       rsp_ready
);
  logic [7:0] rq[$];
  initial begin
    apdu_valid = 1'b0;
    apdu_byte = 8'h00;
    apdu_last = 1'b0;
    rsp_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Sends n bytes, first byte from the top, then drains the answer
  task automatic xfer(input logic [39:0] c, input int n, input int st);
    int i;
    int k;
    bit done;
    rq.delete();
    for (i = 0; i < n; i++) begin
      apdu_valid <= 1'b1;
      apdu_byte <= c[39-8*i -: 8];
      apdu_last <= (i == n - 1);
      do @(posedge mclk); while (apdu_ready !== 1'b1);
    end
    // Released line shows the inverse so stale data never matches
    apdu_valid <= 1'b0;
    apdu_last <= 1'b0;
    apdu_byte <= ~apdu_byte;
    rsp_ready <= (st == 0);
    k = 0;
    done = 0;
    // Stalling reader accepts only every third cycle
    while (!done) begin
      @(posedge mclk);
      if (rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
        rq.push_back(rsp_byte);
        done = (rsp_last === 1'b1);
      end
      k++;
      rsp_ready <= !done && (st == 0 || k % 3 == 0);
    end
  endtask
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [31:0] F0 = 32'h07FE0008;
  logic        mclk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] dat_o;
  logic [31:0] rd;
  logic        ack;
  logic        a_v, a_l, a_r, r_v, r_l, r_r;
  logic [7:0]  a_b, r_b;
  int          failures = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #50 mclk = ~mclk;
  pbr_read_cmd pbr_read_cmd_i (.mclk(mclk), .resetn(resetn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .apdu_valid(a_v), .apdu_byte(a_b), .apdu_last(a_l), .apdu_ready(a_r), .rsp_valid(r_v),
    .rsp_byte(r_b), .rsp_last(r_l), .rsp_ready(r_r));
  pbr_rdr rdr_i (.mclk(mclk), .apdu_valid(a_v), .apdu_byte(a_b), .apdu_last(a_l), .apdu_ready(a_r),
    .rsp_valid(r_v), .rsp_byte(r_b), .rsp_last(r_l), .rsp_ready(r_r));
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well above the whole run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Data bytes are expected as a first value plus their position
  task automatic cmd_chk(input logic [39:0] c, input int n, input int st, input logic [7:0] f, input int cnt,
                         input logic [15:0] sw);
    int i;
    rdr_i.xfer(c, n, st);
    chk("rsp_count", cnt + 2, rdr_i.rq.size());
    for (i = 0; i < cnt && i < rdr_i.rq.size(); i++)
      chk("rsp_data", f + i, rdr_i.rq[i]);
    chk("status_word", sw, {rdr_i.rq[cnt], rdr_i.rq[cnt+1]});
  endtask
  task automatic row(input logic [31:0] ctl, input logic [31:0] fa, input logic [39:0] c, input int n,
                     input logic [15:0] sw);
    wb(1'b1, 8'h00, ctl);
    wb(1'b1, 8'h40, fa);
    cmd_chk(c, n, 0, 8'hA0, (sw == 16'h9000), sw);
    wb(1'b0, 8'h04, 32'h0);
    chk("status_reg", {16'h0000, sw}, rd);
  endtask
  // Enable low freezes a pending bus request; answered once enable returns
  task automatic ce_chk;
    @(posedge mclk);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b0;
    sel <= 4'hF;
    adr <= 8'h08;
    repeat (3) @(posedge mclk);
    chk("ack_frozen", 32'h0, {31'h0, ack});
    ce <= 1'b1;
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Eight loaded bytes leave the load address at eight
    chk("maddr_after_freeze", 32'h00000008, rd);
  endtask
  // File of 300 bytes in slot 1: Le of zero must stop at 256 data bytes
  task automatic long_read;
    int i;
    wb(1'b1, 8'h44, 32'h0BFE012C);
    wb(1'b1, 8'h08, 32'h00008000);
    for (i = 0; i < 300; i++)
      wb(1'b1, 8'h0C, i);
    cmd_chk(40'h00B0820000, 5, 0, 8'h00, 256, 16'h9000);
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl_select", 32'h00000110, rd);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    int i;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    wb(1'b0, 8'h04, 32'h0);
    chk("status_reset", 32'h00009000, rd);
    wb(1'b0, 8'h80, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 8'h40, F0);
    wb(1'b0, 8'h40, 32'h0);
    chk("fattr", F0, rd);
    wb(1'b1, 8'h08, 32'h0);
    for (i = 0; i < 8; i++)
      wb(1'b1, 8'h0C, 32'hA0 + i);
    ce_chk();
    // Good reads, back to back, with and without a stalling reader
    cmd_chk(40'h00B0810203, 5, 0, 8'hA2, 3, 16'h9000);
    cmd_chk(40'h00B0000100, 5, 1, 8'hA1, 7, 16'h9000);
    cmd_chk(40'h00B08005FF, 5, 1, 8'hA5, 3, 16'h9000);
    long_read();
    // Refusals, one cause at a time apart from a short command with chaining set, plus one read granted by the write right alone
    row(32'h0, F0, 40'h00B0810001, 4, 16'h6700);
    row(32'h4, F0, 40'h00B0810001, 4, 16'h6700);
    row(32'h0, F0, 40'h80B0810001, 5, 16'h6E00);
    row(32'h0, F0, 40'h00B0A10001, 5, 16'h6A86);
    row(32'h0, F0, 40'h00B09F0001, 5, 16'h6A86);
    row(32'h0, F0, 40'h00B0850001, 5, 16'h6A82);
    row(32'h0, 32'h06FE0008, 40'h00B0810001, 5, 16'h6985);
    row(32'h4, F0, 40'h00B0810001, 5, 16'h6985);
    row(32'h0, F0, 40'h00B0000001, 5, 16'h6985);
    row(32'h8, F0, 40'h00B0810001, 5, 16'h6985);
    row(32'h0, 32'h07FF0008, 40'h00B0810001, 5, 16'h6982);
    row(32'h0, 32'h07230008, 40'h00B0810001, 5, 16'h6982);
    row(32'h1, F0, 40'h00B0810001, 5, 16'h6982);
    row(32'h2, F0, 40'h00B0810001, 5, 16'h6982);
    row(32'h0, 32'h07EF0008, 40'h00B0810001, 5, 16'h9000);
    row(32'h10, F0, 40'h00B0000801, 5, 16'h6A86);
    end_of_test();
  end
endmodule
`default_nettype wire
